// >>> bench/aft_checker.sv
// Concurrent checks on the ports of aft_top.
// Assumes one clock domain, mclk, and an asynchronous active-low reset.
`timescale 1ns/10ps
module aft_checker #(
    parameter MEAS_WIDTH = 16
) (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata_r,
    input wire reg_rvalid_r,
    // Conversion results
    input wire temp_done,
    input wire supply_done,
    input wire monitor_a_done,
    input wire monitor_b_done,
    input wire [MEAS_WIDTH-1:0] temp_meas,
    input wire [MEAS_WIDTH-1:0] supply_meas,
    input wire [MEAS_WIDTH-1:0] analog_monitor_a,
    input wire [MEAS_WIDTH-1:0] analog_monitor_b,
    // Programmed limits
    input wire [MEAS_WIDTH-1:0] temp_high_limit,
    input wire [MEAS_WIDTH-1:0] temp_low_limit,
    input wire [MEAS_WIDTH-1:0] supply_high_limit,
    input wire [MEAS_WIDTH-1:0] supply_low_limit,
    input wire [MEAS_WIDTH-1:0] monitor_a_high_limit,
    input wire [MEAS_WIDTH-1:0] monitor_a_low_limit,
    input wire [MEAS_WIDTH-1:0] monitor_b_high_limit,
    input wire [MEAS_WIDTH-1:0] monitor_b_low_limit,
    // Interrupt enable mask
    input wire [7:0] interrupt_enable_mask,
    // Status and table select
    input wire [7:0] limit_alarm_flags_r,
    input wire masked_interrupt_summary_r,
    input wire [1:0] memory_table_select_r,
    input wire [3:0] table_active_r,
    // Buffer one pin
    input wire buf1_out_r,
    input wire buf1_oe_r
);
    reg [7:0] exp_r;
    // Reference flags; equal to a limit is no alarm
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            exp_r <= 8'h00;
        end else begin
            if (temp_done)
                exp_r[7:6] <= {$signed(temp_meas) > $signed(temp_high_limit),
                    $signed(temp_meas) < $signed(temp_low_limit)};
            if (supply_done)
                exp_r[5:4] <= {supply_meas > supply_high_limit, supply_meas < supply_low_limit};
            if (monitor_a_done)
                exp_r[3:2] <= {analog_monitor_a > monitor_a_high_limit,
                    analog_monitor_a < monitor_a_low_limit};
            if (monitor_b_done)
                exp_r[1:0] <= {analog_monitor_b > monitor_b_high_limit,
                    analog_monitor_b < monitor_b_low_limit};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_flags_track: assert property (limit_alarm_flags_r == exp_r)
        else $error("flag byte differs from limit comparison");
    a_summary_masked: assert property ($stable(limit_alarm_flags_r) && $stable(interrupt_enable_mask)
        |-> masked_interrupt_summary_r == |(limit_alarm_flags_r & interrupt_enable_mask))
        else $error("summary differs from masked flags");
    a_mask_zero: assert property ((interrupt_enable_mask == 8'h00) [*2]
        |-> !masked_interrupt_summary_r) else $error("summary set with empty mask");
    a_buf_follows: assert property (buf1_oe_r == masked_interrupt_summary_r && !buf1_out_r)
        else $error("buffer one pin does not follow summary");
    a_sel_write: assert property (reg_wr && reg_addr == 8'h7f
        |=> {6'h00, memory_table_select_r} == ($past(reg_wdata) & 8'h03))
        else $error("table select not written");
    a_sel_hold: assert property (!(reg_wr && reg_addr == 8'h7f)
        |=> $stable(memory_table_select_r)) else $error("table select changed unasked");
    a_table_onehot: assert property (table_active_r == (4'h1 << memory_table_select_r))
        else $error("active table differs from select");
    a_read_valid: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read gave no valid pulse");
    a_read_sel: assert property (reg_rd && reg_addr == 8'h7f
        |=> reg_rdata_r == {6'h00, $past(memory_table_select_r)}) else $error("select read wrong");
endmodule
bind aft_top aft_checker #(.MEAS_WIDTH(MEAS_WIDTH)) u_chk (.*);

// >>> bench/aft_conv_model.sv
// Conversion engine model: measurement, done pulse and fixed limits.
// Assumes mclk from the bench; limits are held constant.
`timescale 1ns/10ps
module aft_conv_model (
    // Clock
    input wire mclk,
    // Done pulses, bit 3 temperature down to bit 0 monitor B
    output reg [3:0] done,
    // Measurements
    output reg [15:0] m3,
    output reg [15:0] m2,
    output reg [15:0] m1,
    output reg [15:0] m0,
    // Limits: unsigned channels, then temperature
    output wire [15:0] hi_u,
    output wire [15:0] lo_u,
    output wire [15:0] hi_t,
    output wire [15:0] lo_t
);
    assign hi_u = 16'h8000;
    assign lo_u = 16'h1000;
    assign hi_t = 16'h0050;
    assign lo_t = 16'hfff0;
    initial begin
        done = 4'h0;
        {m3, m2, m1, m0} = 64'h0;
    end
    // Result only valid with done; inverted afterwards to catch late sampling
    task convert(input [1:0] ch, input [15:0] v);
        @(posedge mclk);
        #1;
        case (ch)
            2'd3: m3 = v;
            2'd2: m2 = v;
            2'd1: m1 = v;
            default: m0 = v;
        endcase
        done[ch] = 1'b1;
        @(posedge mclk);
        #1;
        done[ch] = 1'b0;
        case (ch)
            2'd3: m3 = ~v;
            2'd2: m2 = ~v;
            2'd1: m1 = ~v;
            default: m0 = ~v;
        endcase
    endtask
endmodule

// >>> bench/alarm_flags_table_select_bench.sv
// Self-checking bench for aft_top: register port calls and conversions.
// Assumes aft_conv_model drives the conversion results and limits.
`timescale 1ns/10ps
module alarm_flags_table_select_bench;
    reg mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, mask = 8'h00;
    reg [15:0] hi, lo;
    wire [7:0] rdata, flags;
    wire rvalid, summary, buf_out, buf_oe;
    wire [1:0] sel;
    wire [3:0] act, done;
    wire [15:0] m3, m2, m1, m0, hi_u, lo_u, hi_t, lo_t;
    integer mismatches = 0, n_checks = 0, cycles = 0, ch;
    always #5 mclk = ~mclk;
    aft_conv_model model (.mclk(mclk), .done(done), .m3(m3), .m2(m2), .m1(m1), .m0(m0),
        .hi_u(hi_u), .lo_u(lo_u), .hi_t(hi_t), .lo_t(lo_t));
    aft_top dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
        .temp_done(done[3]), .supply_done(done[2]), .monitor_a_done(done[1]),
        .monitor_b_done(done[0]), .temp_meas(m3), .supply_meas(m2), .analog_monitor_a(m1),
        .analog_monitor_b(m0), .temp_high_limit(hi_t), .temp_low_limit(lo_t),
        .supply_high_limit(hi_u), .supply_low_limit(lo_u), .monitor_a_high_limit(hi_u),
        .monitor_a_low_limit(lo_u), .monitor_b_high_limit(hi_u), .monitor_b_low_limit(lo_u),
        .interrupt_enable_mask(mask), .limit_alarm_flags_r(flags),
        .masked_interrupt_summary_r(summary), .memory_table_select_r(sel),
        .table_active_r(act), .buf1_out_r(buf_out), .buf1_oe_r(buf_oe));
    task check(input [7:0] s, input [7:0] e);
        n_checks = n_checks + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge mclk);
        #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        check(rdata, e);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 resetn = 1'b1;
        rd(8'h70, 8'h00);
        rd(8'h71, 8'h00);
        check({4'h0, act}, 8'h01);
        $display("test reset done");
        for (ch = 0; ch < 4; ch = ch + 1) begin
            wr(8'h7f, 8'hfc | ch[7:0]);
            rd(8'h7f, ch[7:0]);
            check({4'h0, act}, 8'h01 << ch);
        end
        wr(8'h70, 8'hff);
        rd(8'h7f, 8'h03);
        rd(8'h70, 8'h00);
        rd(8'h75, 8'h00);
        rd(8'h10, 8'h00);
        $display("test select done");
        mask = 8'hff;
        for (ch = 0; ch < 4; ch = ch + 1) begin
            hi = (ch == 3) ? 16'h0050 : 16'h8000;
            lo = (ch == 3) ? 16'hfff0 : 16'h1000;
            model.convert(ch[1:0], hi + 16'h0001);
            rd(8'h70, 8'h02 << (2 * ch));
            model.convert(ch[1:0], lo - 16'h0001);
            rd(8'h70, 8'h01 << (2 * ch));
            rd(8'h71, 8'h01);
            check({7'h00, buf_oe}, 8'h01);
            model.convert(ch[1:0], hi);
            rd(8'h70, 8'h00);
        end
        $display("test flags done");
        model.convert(2'd1, 16'h0fff);
        mask = 8'hfb;
        rd(8'h71, 8'h00);
        mask = 8'h04;
        rd(8'h71, 8'h01);
        mask = 8'h00;
        rd(8'h71, 8'h00);
        check({7'h00, buf_oe}, 8'h00);
        $display("test mask done");
        summarize;
    end
endmodule

// >>> common/aft_map.vh
// Register map, field positions and reset values of the alarm-flag and
// table-select bank. Definitions only; included only by the top-level design file.
`ifndef AFT_MAP_VH
`define AFT_MAP_VH

// Byte offsets on the internal register port
`define AFT_LIMIT_ALARM_FLAGS_OFS 8'h70
`define AFT_ALARM_SUMMARY_OFS 8'h71
`define AFT_RESERVED_FIRST_OFS 8'h72
`define AFT_RESERVED_LAST_OFS 8'h7e
`define AFT_MEMORY_TABLE_SELECT_OFS 8'h7f

// Bit positions inside the limit alarm flag byte
`define AFT_TEMPERATURE_HIGH_BIT 7
`define AFT_TEMPERATURE_LOW_BIT 6
`define AFT_SUPPLY_HIGH_BIT 5
`define AFT_SUPPLY_LOW_BIT 4
`define AFT_MONITOR_A_HIGH_BIT 3
`define AFT_MONITOR_A_LOW_BIT 2
`define AFT_MONITOR_B_HIGH_BIT 1
`define AFT_MONITOR_B_LOW_BIT 0

// Bit position of the summary inside the alarm summary byte
`define AFT_MASKED_SUMMARY_BIT 0

// Table select field
`define AFT_TABLE_SELECT_MSB 1
`define AFT_TABLE_SELECT_LSB 0

// Reset values
`define AFT_LIMIT_ALARM_FLAGS_RST 8'h00
`define AFT_MEMORY_TABLE_SELECT_RST 2'h0
`define AFT_READ_DATA_RST 8'h00
`define AFT_TABLE_ACTIVE_RST 4'h1
`define AFT_SUMMARY_RST 1'h0
`define AFT_RESERVED_RST 8'h00

`endif

// >>> rtl/aft_cmp.v
// One channel's limit comparator: flags a measurement above its upper
// limit or below its lower limit. Purely combinational, same clock domain.
`timescale 1ns/10ps

module aft_cmp #(
    parameter WIDTH = 16,
    parameter SIGNED_CMP = 0
) (
    // Measurement and limits
    input wire [WIDTH-1:0] value,
    input wire [WIDTH-1:0] high_limit,
    input wire [WIDTH-1:0] low_limit,
    // Violations
    output wire above_high,
    output wire below_low
);

    wire [WIDTH-1:0] flip;

    // Offset binary turns a signed compare into an unsigned one
    assign flip = (SIGNED_CMP != 0) ? {1'h1, {(WIDTH-1){1'h0}}} : {WIDTH{1'h0}};
    assign above_high = (value ^ flip) > (high_limit ^ flip);
    assign below_low = (value ^ flip) < (low_limit ^ flip);

endmodule

// >>> rtl/aft_top.v
// Alarm flags, masked interrupt summary and memory table select.
// Assumes the serial interface, conversion engine and mask storage run on
// mclk and hand over plain same-clock signals; no synchronisers needed.
`timescale 1ns/10ps
`include "aft_map.vh"

module aft_top #(
    parameter MEAS_WIDTH = 16
) (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Register port from the serial interface
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    output reg reg_rvalid_r,
    // Conversion results, one done pulse per channel
    input wire temp_done,
    input wire supply_done,
    input wire monitor_a_done,
    input wire monitor_b_done,
    input wire [MEAS_WIDTH-1:0] temp_meas,
    input wire [MEAS_WIDTH-1:0] supply_meas,
    input wire [MEAS_WIDTH-1:0] analog_monitor_a,
    input wire [MEAS_WIDTH-1:0] analog_monitor_b,
    // Programmed limits
    input wire [MEAS_WIDTH-1:0] temp_high_limit,
    input wire [MEAS_WIDTH-1:0] temp_low_limit,
    input wire [MEAS_WIDTH-1:0] supply_high_limit,
    input wire [MEAS_WIDTH-1:0] supply_low_limit,
    input wire [MEAS_WIDTH-1:0] monitor_a_high_limit,
    input wire [MEAS_WIDTH-1:0] monitor_a_low_limit,
    input wire [MEAS_WIDTH-1:0] monitor_b_high_limit,
    input wire [MEAS_WIDTH-1:0] monitor_b_low_limit,
    // Interrupt enable mask, bit i gates flag bit i
    input wire [7:0] interrupt_enable_mask,
    // Status and table select
    output reg [7:0] limit_alarm_flags_r,
    output reg masked_interrupt_summary_r,
    output reg [1:0] memory_table_select_r,
    output reg [3:0] table_active_r,
    // Open-drain buffer one output
    output reg buf1_out_r,
    output reg buf1_oe_r
);

    localparam NCH = 4;

    // One-hot table decode, applied to the next select value to load the register
    function [3:0] table_onehot;
        input [1:0] sel;
        begin
            table_onehot = 4'h1 << sel;
        end
    endfunction

    // Address match, shared by the write and the read decode so the two
    // can never disagree on where a register lives
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // Reserved window between the summary and the select byte
    function addr_reserved;
        input [7:0] addr;
        begin
            addr_reserved = (addr >= `AFT_RESERVED_FIRST_OFS) &&
                (addr <= `AFT_RESERVED_LAST_OFS);
        end
    endfunction

    wire [NCH-1:0] done_vec;
    wire [NCH*MEAS_WIDTH-1:0] meas_vec;
    wire [NCH*MEAS_WIDTH-1:0] high_vec;
    wire [NCH*MEAS_WIDTH-1:0] low_vec;
    wire [NCH-1:0] above_vec;
    wire [NCH-1:0] below_vec;
    reg [7:0] limit_alarm_flags_nxt;
    reg [1:0] memory_table_select_nxt;
    reg [7:0] reg_rdata_nxt;
    wire masked_interrupt_summary_nxt;
    wire [7:0] masked_flags_nxt;

    // Channel 3 temperature, 2 supply, 1 monitor A, 0 monitor B
    assign done_vec = {temp_done, supply_done, monitor_a_done, monitor_b_done};
    assign meas_vec = {temp_meas, supply_meas, analog_monitor_a, analog_monitor_b};
    assign high_vec = {temp_high_limit, supply_high_limit,
                       monitor_a_high_limit, monitor_b_high_limit};
    assign low_vec = {temp_low_limit, supply_low_limit,
                      monitor_a_low_limit, monitor_b_low_limit};

    // Only temperature is two's complement
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_cmp
            aft_cmp #(
                .WIDTH(MEAS_WIDTH),
                .SIGNED_CMP((ch == NCH - 1) ? 1 : 0)
            ) u_cmp (
                .value(meas_vec[ch*MEAS_WIDTH +: MEAS_WIDTH]),
                .high_limit(high_vec[ch*MEAS_WIDTH +: MEAS_WIDTH]),
                .low_limit(low_vec[ch*MEAS_WIDTH +: MEAS_WIDTH]),
                .above_high(above_vec[ch]),
                .below_low(below_vec[ch])
            );
        end
    endgenerate

    // Channel ch owns flag bits 2*ch+1 (high) and 2*ch (low)
    integer i;
    always @* begin
        limit_alarm_flags_nxt = limit_alarm_flags_r;
        for (i = 0; i < NCH; i = i + 1) begin
            // Flags follow only a finished conversion, so a half-updated
            // result never glitches the interrupt
            if (done_vec[i]) begin
                limit_alarm_flags_nxt[2*i+1] = above_vec[i];
                limit_alarm_flags_nxt[2*i] = below_vec[i];
            end
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            limit_alarm_flags_r <= `AFT_LIMIT_ALARM_FLAGS_RST;
        end else begin
            limit_alarm_flags_r <= limit_alarm_flags_nxt;
        end
    end

    // Per-flag gating by the enable mask
    genvar fb;
    generate
        for (fb = 0; fb < 2 * NCH; fb = fb + 1) begin : g_mask
            assign masked_flags_nxt[fb] =
                limit_alarm_flags_nxt[fb] & interrupt_enable_mask[fb];
        end
    endgenerate

    // Computed from the next flag value so that the summary and the flag
    // byte change on the same edge
    assign masked_interrupt_summary_nxt =
        |masked_flags_nxt;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            masked_interrupt_summary_r <= `AFT_SUMMARY_RST;
            buf1_out_r <= 1'h0;
            buf1_oe_r <= `AFT_SUMMARY_RST;
        end else begin
            masked_interrupt_summary_r <= masked_interrupt_summary_nxt;
            // Open drain: pulls low while the summary is set
            buf1_out_r <= 1'h0;
            buf1_oe_r <= masked_interrupt_summary_nxt;
        end
    end

    // Table select write; upper bits are not stored
    always @* begin
        memory_table_select_nxt = memory_table_select_r;
        if (reg_wr && addr_hit(reg_addr, `AFT_MEMORY_TABLE_SELECT_OFS)) begin
            memory_table_select_nxt =
                reg_wdata[`AFT_TABLE_SELECT_MSB:`AFT_TABLE_SELECT_LSB];
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            memory_table_select_r <= `AFT_MEMORY_TABLE_SELECT_RST;
            table_active_r <= `AFT_TABLE_ACTIVE_RST;
        end else begin
            memory_table_select_r <= memory_table_select_nxt;
            table_active_r <= table_onehot(memory_table_select_nxt);
        end
    end

    // Read decode; unknown and reserved locations answer zero
    always @* begin
        reg_rdata_nxt = 8'h00;
        if (addr_hit(reg_addr, `AFT_LIMIT_ALARM_FLAGS_OFS)) begin
            reg_rdata_nxt = limit_alarm_flags_r;
        end else if (addr_hit(reg_addr, `AFT_ALARM_SUMMARY_OFS)) begin
            reg_rdata_nxt[`AFT_MASKED_SUMMARY_BIT] = masked_interrupt_summary_r;
        end else if (addr_reserved(reg_addr)) begin
            reg_rdata_nxt = `AFT_RESERVED_RST;
        end else if (addr_hit(reg_addr, `AFT_MEMORY_TABLE_SELECT_OFS)) begin
            reg_rdata_nxt[`AFT_TABLE_SELECT_MSB:`AFT_TABLE_SELECT_LSB] =
                memory_table_select_r;
        end else begin
            reg_rdata_nxt = 8'h00;
        end
    end

    // Read data is held until the next read
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= `AFT_READ_DATA_RST;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= reg_rdata_nxt;
            end
        end
    end

endmodule
